// File: inc/mmd_pkg.sv
// Memory map constants and types for the address decoder with remap
package mmd_pkg;
  // Low window that mirrors either memory
  localparam logic [31:0] WINDOW_SIZE = 32'h0001_0000;
  // On-chip SRAM: 4 kB as 1024 words of 32 bits
  localparam logic [31:0] SRAM_BASE   = 32'h0004_0000;
  localparam logic [31:0] SRAM_SIZE   = 32'h0000_1000;
  localparam int          SRAM_WORDS  = 1024;
  localparam int          SRAM_AW     = 10;
  // Nonvolatile array: 64 kB, 16 bits wide, top 2 kB hidden boot code
  localparam logic [31:0] FLASH_BASE  = 32'h0008_0000;
  localparam logic [31:0] FLASH_SIZE  = 32'h0001_0000;
  localparam logic [31:0] KERNEL_OFS  = 32'h0000_F800;
  localparam logic [31:0] KERNEL_SIZE = 32'h0000_0800;
  localparam int          FLASH_HALVES = 32768;
  localparam int          FLASH_HAW   = 15;
  localparam int          FLASH_WAW   = 14;
  // Top 4 kB routed to the peripheral register space
  localparam logic [31:0] PERIPH_BASE = 32'hFFFF_F000;
  localparam int          PERIPH_AW   = 12;
  // Local registers
  localparam logic [31:0] REMAP_ADDR  = 32'hFFFF_0220;
  localparam logic [31:0] BOOT_ADDR   = 32'hFFFF_0224;
  localparam int          REMAP_BIT   = 0;
  localparam int          KMODE_BIT   = 0;
  localparam int          TRST_BIT    = 1;
  localparam logic        REMAP_RESET = 1'b0;
  // Avalon-MM response codes
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_DECERR = 2'h3;
  // Target of one access
  typedef enum logic [2:0] {
    MMD_NONE,
    MMD_SRAM,
    MMD_FLASH,
    MMD_PERIPH,
    MMD_REMAP,
    MMD_BOOT
  } mmd_region_t;
endpackage : mmd_pkg

// File: hw/mmd_sram.sv
// 1024 x 32 SRAM with per-byte write lanes and same-cycle read
module mmd_sram (
  input  wire logic        clk_sys,
  input  wire logic [9:0]  wordIdx,
  input  wire logic        wrEn,
  input  wire logic [3:0]  laneEn,
  input  wire logic [31:0] wrData,
  output logic      [31:0] rdData
);
  // Storage array, word wide so code runs with no wait state
  logic [31:0] mem [mmd_pkg::SRAM_WORDS];

  // One write process per byte lane, byte 0 is lowest address
  for (genvar b = 0; b < 4; b++) begin : gLane
    always_ff @(posedge clk_sys) begin
      if (wrEn && laneEn[b]) begin
        mem[wordIdx][8*b +: 8] <= wrData[8*b +: 8];
      end
    end
  end

  // Read is combinational: answer in the request cycle
  assign rdData = mem[wordIdx];
endmodule : mmd_sram

// File: hw/mmd_flash_array.sv
// 16-bit nonvolatile array read as two halves per 32-bit word
module mmd_flash_array (
  input  wire logic        clk_sys,
  input  wire logic [13:0] wordIdx,
  output logic      [31:0] rdData,
  input  wire logic        progWrite,
  input  wire logic [14:0] progAddress,
  input  wire logic [15:0] progData
);
  // Halfword array, loaded only by the outside programming controller
  logic [15:0] mem [mmd_pkg::FLASH_HALVES];
  // Addresses of the two halves of one word
  logic [14:0] loIdx;
  logic [14:0] hiIdx;

  // Programming port from the outside controller
  always_ff @(posedge clk_sys) begin
    if (progWrite) begin
      mem[progAddress] <= progData;
    end
  end

  // Both array accesses happen inside one clock; low half first
  assign loIdx  = {wordIdx, 1'b0};
  assign hiIdx  = {wordIdx, 1'b1};
  assign rdData = {mem[hiIdx], mem[loIdx]};
endmodule : mmd_flash_array

// File: hw/mmd_decoder.sv
// Memory map decoder with low window remap, Avalon-MM slave toward the core

// Summary of operation
// - Low 64 kB mirrors selected memory
// - Top 4 kB goes to peripheral registers
// - 4 kB SRAM, 1024 words, at 0x40000
// - Byte, halfword, word accesses touch own lanes
// - SRAM is 32 bits, zero wait states
// - Undefined addresses raise data abort
// - Little endian byte order
// - 62 kB user array, 2 kB boot code
// - Boot code hidden from user accesses
// - After reset array mirrored at zero
// - Remap bit set mirrors SRAM at zero
// - Remap bit clear mirrors array again
// - Vectors served from mirrored memory
// - Reset starts in boot code, then zero
// - External reset input is active low
// - Boot samples debug test reset level
// - Array also decoded at 0x80000
// - Every reset clears the remap bit
// - Two halfword reads per word, one clock
module mmd_decoder (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        extResetN,
  input  wire logic        dbgTestResetN,
  input  wire logic [31:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic      [1:0]  avs_response,
  output logic             dataAbort,
  output logic      [11:0] periphAddress,
  output logic             periphRead,
  output logic             periphWrite,
  output logic      [31:0] periphWritedata,
  output logic      [3:0]  periphByteenable,
  input  wire logic [31:0] periphReaddata,
  input  wire logic        periphWaitrequest,
  input  wire logic        progWrite,
  input  wire logic [14:0] progAddress,
  input  wire logic [15:0] progData,
  output logic             remapActive,
  output logic             kernelMode,
  output logic             linBootSelect
);
  // Reset of every kind: system reset or external pin low
  logic                 sysReset;
  // Remap selection, set means SRAM at address zero
  logic                 remap_r;
  // Boot code is running and owns the low window
  logic                 kernel_r;
  // Test reset level caught after reset release
  logic                 trstSample_r;
  // First cycle after reset release not yet seen
  logic                 capturePending_r;
  // Decoded target and offset into it
  mmd_pkg::mmd_region_t region;
  logic [31:0]          memOfs;
  // Any request this cycle
  logic                 request;
  // Access finishes at this edge
  logic                 accept;
  // Memory read words
  logic [31:0]          sramData;
  logic [31:0]          flashData;
  // Local register read words
  logic [31:0]          remapWord;
  logic [31:0]          bootWord;

  assign sysReset = rst | ~extResetN;
  assign request  = avs_read | avs_write;

  // Decode one address into a target and an offset
  always_comb begin
    region = mmd_pkg::MMD_NONE;
    memOfs = '0;
    if (avs_address < mmd_pkg::WINDOW_SIZE) begin
      // Low window: offset passes through unchanged, except while boot code runs, when KERNEL_OFS is added
      if (kernel_r) begin
        // Boot code answers the reset fetch at zero
        if (avs_address < mmd_pkg::KERNEL_SIZE) begin
          region = mmd_pkg::MMD_FLASH;
          memOfs = mmd_pkg::KERNEL_OFS + avs_address;
        end
      end else if (remap_r) begin
        // SRAM mirrored, only its 4 kB exist
        if (avs_address < mmd_pkg::SRAM_SIZE) begin
          region = mmd_pkg::MMD_SRAM;
          memOfs = avs_address;
        end
      end else begin
        // Array mirrored, hidden top part stays out
        if (avs_address < mmd_pkg::KERNEL_OFS) begin
          region = mmd_pkg::MMD_FLASH;
          memOfs = avs_address;
        end
      end
    end else if (avs_address >= mmd_pkg::SRAM_BASE &&
                 avs_address <  mmd_pkg::SRAM_BASE + mmd_pkg::SRAM_SIZE)
    begin
      // Physical SRAM
      region = mmd_pkg::MMD_SRAM;
      memOfs = avs_address - mmd_pkg::SRAM_BASE;
    end else if (avs_address >= mmd_pkg::FLASH_BASE &&
                 avs_address <  mmd_pkg::FLASH_BASE + mmd_pkg::FLASH_SIZE)
    begin
      // Physical array; boot part only while boot code runs
      memOfs = avs_address - mmd_pkg::FLASH_BASE;
      if (memOfs < mmd_pkg::KERNEL_OFS || kernel_r) begin
        region = mmd_pkg::MMD_FLASH;
      end
    end else if (avs_address >= mmd_pkg::PERIPH_BASE) begin
      // Peripheral register space
      region = mmd_pkg::MMD_PERIPH;
      memOfs = avs_address - mmd_pkg::PERIPH_BASE;
    end else if (avs_address == mmd_pkg::REMAP_ADDR) begin
      region = mmd_pkg::MMD_REMAP;
    end else if (avs_address == mmd_pkg::BOOT_ADDR) begin
      region = mmd_pkg::MMD_BOOT;
    end
  end

  // Only a peripheral may stall; every other target answers at once
  assign avs_waitrequest = request && region == mmd_pkg::MMD_PERIPH &&
                           periphWaitrequest;
  assign accept = request && !avs_waitrequest;

  // Undefined target: access ends with an abort, nothing changes
  assign dataAbort    = accept && region == mmd_pkg::MMD_NONE;
  assign avs_response = (region == mmd_pkg::MMD_NONE) ?
                        mmd_pkg::RESP_DECERR : mmd_pkg::RESP_OKAY;

  // SRAM, written only on an accepted write
  mmd_sram uSram (
    .clk_sys (clk_sys),
    .wordIdx (memOfs[11:2]),
    .wrEn    (accept && avs_write && region == mmd_pkg::MMD_SRAM),
    .laneEn  (avs_byteenable),
    .wrData  (avs_writedata),
    .rdData  (sramData)
  );

  // Nonvolatile array, read-only from the core side
  mmd_flash_array uFlash (
    .clk_sys     (clk_sys),
    .wordIdx     (memOfs[15:2]),
    .rdData      (flashData),
    .progWrite   (progWrite),
    .progAddress (progAddress),
    .progData    (progData)
  );

  // Peripheral forwarding, gated so strays never reach it
  assign periphAddress    = memOfs[11:0];
  assign periphRead       = avs_read  && region == mmd_pkg::MMD_PERIPH;
  assign periphWrite      = avs_write && region == mmd_pkg::MMD_PERIPH;
  assign periphWritedata  = avs_writedata;
  assign periphByteenable = avs_byteenable;

  // Local register images; reserved bits read zero
  always_comb begin
    remapWord = '0;
    bootWord  = '0;
    remapWord[mmd_pkg::REMAP_BIT] = remap_r;
    bootWord[mmd_pkg::KMODE_BIT]  = kernel_r;
    bootWord[mmd_pkg::TRST_BIT]   = trstSample_r;
  end

  // Read data multiplexer; aborted reads return zero
  always_comb begin
    case (region)
      mmd_pkg::MMD_SRAM:   avs_readdata = sramData;
      mmd_pkg::MMD_FLASH:  avs_readdata = flashData;
      mmd_pkg::MMD_PERIPH: avs_readdata = periphReaddata;
      mmd_pkg::MMD_REMAP:  avs_readdata = remapWord;
      mmd_pkg::MMD_BOOT:   avs_readdata = bootWord;
      default:             avs_readdata = '0;
    endcase
  end

  // Remap bit: cleared by any reset, written via lane 0 only
  always_ff @(posedge clk_sys) begin
    if (sysReset) begin
      remap_r <= mmd_pkg::REMAP_RESET;
    end else if (accept && avs_write && avs_byteenable[0] &&
                 region == mmd_pkg::MMD_REMAP) begin
      // Upper bits are reserved and not stored
      remap_r <= avs_writedata[mmd_pkg::REMAP_BIT];
    end
  end

  // Boot ownership: on at reset, off when boot code writes exit bit
  always_ff @(posedge clk_sys) begin
    if (sysReset) begin
      kernel_r <= 1'b1;
    end else if (accept && avs_write && avs_byteenable[0] &&
                 region == mmd_pkg::MMD_BOOT &&
                 avs_writedata[mmd_pkg::KMODE_BIT]) begin
      // Cannot be re-entered without a reset, so user code stays out
      kernel_r <= 1'b0;
    end
  end

  // Test reset level caught once, on the first edge after release
  always_ff @(posedge clk_sys) begin
    if (sysReset) begin
      capturePending_r <= 1'b1;
      trstSample_r     <= 1'b0;
    end else if (capturePending_r) begin
      capturePending_r <= 1'b0;
      trstSample_r     <= dbgTestResetN;
    end
  end

  // Status toward the rest of the chip
  assign remapActive   = remap_r;
  assign kernelMode    = kernel_r;
  assign linBootSelect = trstSample_r;
endmodule : mmd_decoder

// File: verification/mmd_decoder_asserts.sv
// Port relation checker for the memory map decoder
module mmd_decoder_asserts (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        extResetN,
  input wire logic [31:0] avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic [1:0]  avs_response,
  input wire logic        dataAbort,
  input wire logic [11:0] periphAddress,
  input wire logic        periphWaitrequest,
  input wire logic        remapActive,
  input wire logic        kernelMode
);
  timeunit 1ns;
  timeprecision 1ns;
  logic req;  // Any request on the bus
  assign req = avs_read || avs_write;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst || !extResetN);
  property p_sramZeroWait;
    req && avs_address[31:12] == 20'h00040 |-> !avs_waitrequest;
  endproperty
  a_sramZeroWait: assert property (p_sramZeroWait)
    else $error("SRAM access stalled");
  property p_abortResp;
    dataAbort |-> req && avs_response == 2'h3;
  endproperty
  a_abortResp: assert property (p_abortResp)
    else $error("Abort without error response");
  property p_abortRead;
    dataAbort && avs_read |-> avs_readdata == 32'h0;
  endproperty
  a_abortRead: assert property (p_abortRead)
    else $error("Aborted read returned data");
  // Stall of the register space must reach the core unchanged
  property p_periphFwd;
    req && avs_address[31:12] == 20'hFFFFF |-> periphAddress ==
      avs_address[11:0] && avs_waitrequest == periphWaitrequest;
  endproperty
  a_periphFwd: assert property (p_periphFwd)
    else $error("Register space not forwarded");
  property p_remapWrite;
    avs_write && !avs_waitrequest && avs_byteenable[0] &&
      avs_address == mmd_pkg::REMAP_ADDR |=>
      remapActive == $past(avs_writedata[0]);
  endproperty
  a_remapWrite: assert property (p_remapWrite)
    else $error("Remap bit did not follow write");
  // Own disable: this one must hold while reset is applied
  property p_rstClear;
    disable iff (1'b0) (rst || !extResetN) |=> !remapActive && kernelMode;
  endproperty
  a_rstClear: assert property (p_rstClear)
    else $error("Reset left remap selection");
  property p_windowSram;
    req && remapActive && !kernelMode && avs_address[31:12] == 20'h0 |->
      avs_response == 2'h0;
  endproperty
  a_windowSram: assert property (p_windowSram)
    else $error("Window refused SRAM offset");
  property p_windowSize;
    req && remapActive && avs_address[31:16] == 16'h0 &&
      avs_address[15:12] != 4'h0 |-> dataAbort;
  endproperty
  a_windowSize: assert property (p_windowSize)
    else $error("Window beyond SRAM not aborted");
  property p_bootHidden;
    req && !kernelMode && avs_address[31:11] == 21'h00011F |-> dataAbort;
  endproperty
  a_bootHidden: assert property (p_bootHidden)
    else $error("Boot area reached by user");
  c_abort: cover property (dataAbort);
  c_stall: cover property (req && avs_waitrequest);
  c_remap: cover property ($rose(remapActive));
endmodule : mmd_decoder_asserts

bind mmd_decoder mmd_decoder_asserts u_chk (.clk_sys, .rst, .extResetN,
  .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
  .avs_readdata, .avs_waitrequest, .avs_response, .dataAbort,
  .periphAddress, .periphWaitrequest, .remapActive, .kernelMode);

// File: verification/mmd_periph_model.sv
// Register space responder with a settable stall
module mmd_periph_model (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic [3:0]  stallCycles,
  input  wire logic [11:0] periphAddress,
  input  wire logic        periphRead,
  input  wire logic        periphWrite,
  input  wire logic [31:0] periphWritedata,
  output logic      [31:0] periphReaddata,
  output logic             periphWaitrequest
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0]  waitCnt_r;  // Cycles stalled so far
  logic [31:0] store_r;    // Last accepted write
  logic        req;
  assign req = periphRead || periphWrite;
  // Stall the set count, then answer once
  assign periphWaitrequest = req && (waitCnt_r < stallCycles);
  // Inverted value outside the answer, so stale data never matches
  assign periphReaddata = (periphRead && !periphWaitrequest) ?
    (store_r ^ {20'h0, periphAddress}) : ~store_r;
  // Stall counter restarts after each answer
  always_ff @(posedge clk_sys) begin
    if (rst || !req || !periphWaitrequest) waitCnt_r <= 4'h0;
    else waitCnt_r <= waitCnt_r + 4'h1;
  end
  // Write storage
  always_ff @(posedge clk_sys) begin
    if (rst) store_r <= 32'h0;
    else if (periphWrite && !periphWaitrequest) store_r <= periphWritedata;
  end
endmodule : mmd_periph_model

// File: verification/test_memory_map_decoder_with_remap.sv
// Self-checking bench for the memory map decoder
module test_memory_map_decoder_with_remap;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic w; logic [31:0] a; logic [3:0] be; logic [31:0] d; logic [1:0] rs;
  } mmd_row_t;  // Direction, address, lanes, data or expected, response
  logic clk_sys = 0, rst = 1, extResetN = 1, dbgTestResetN = 0;
  logic [31:0] avs_address = 0, avs_writedata = 0, avs_readdata;
  logic avs_read = 0, avs_write = 0, avs_waitrequest, dataAbort;
  logic [3:0] avs_byteenable = 0, periphByteenable, stallCycles = 0;
  logic [1:0] avs_response;
  logic [11:0] periphAddress;
  logic periphRead, periphWrite, periphWaitrequest, progWrite = 0;
  logic [31:0] periphWritedata, periphReaddata, rd;
  logic [14:0] progAddress = 0;
  logic [15:0] progData = 0;
  logic remapActive, kernelMode, linBootSelect, ab;
  logic [1:0] rs;
  int fails = 0, n_tests = 0, nCyc, cyc = 0;
  mmd_row_t rows [24];
  always #20 clk_sys = ~clk_sys;
  mmd_decoder u_dut (.clk_sys, .rst, .extResetN, .dbgTestResetN,
    .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest, .avs_response, .dataAbort,
    .periphAddress, .periphRead, .periphWrite, .periphWritedata,
    .periphByteenable, .periphReaddata, .periphWaitrequest, .progWrite,
    .progAddress, .progData, .remapActive, .kernelMode, .linBootSelect);
  mmd_periph_model u_periph (.clk_sys, .rst, .stallCycles, .periphAddress,
    .periphRead, .periphWrite, .periphWritedata, .periphReaddata,
    .periphWaitrequest);
  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
      fails++;
    end
  endtask : chk
  // Request is left up so the next call runs back to back
  task automatic acc(input mmd_row_t r);
    int n;
    n = 0;
    avs_write <= r.w;
    avs_read <= !r.w;
    avs_address <= r.a;
    avs_byteenable <= r.be;
    avs_writedata <= r.d;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0); // Waits until waitrequest is 0; only the hang guard ends a wait that never drops
    rd = avs_readdata;
    rs = avs_response;
    ab = dataAbort;
    nCyc = n;
  endtask : acc
  task automatic finish_test;
    $display("tests=%0d fails=%0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : finish_test
  // Hang guard
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc > 2000) begin
      fails++;
      finish_test();
    end
  end
  initial begin
    rows = '{'{0, 32'h00000000, 4'hF, 32'hAAAABBBB, 0},
      '{0, 32'h00080000, 4'hF, 32'h12345678, 0},
      '{0, 32'h0008F800, 4'hF, 32'hAAAABBBB, 0},
      '{1, 32'h00080000, 4'hF, 32'h00000000, 0},
      '{0, 32'h00080000, 4'hF, 32'h12345678, 0},
      '{1, 32'h00040000, 4'hF, 32'h11223344, 0},
      '{1, 32'h00040000, 4'h2, 32'h0000EE00, 0},
      '{0, 32'h00040000, 4'hF, 32'h1122EE44, 0},
      '{0, 32'h00041000, 4'hF, 32'h00000000, 3},
      '{1, 32'hFFFF0224, 4'h1, 32'h00000001, 0},
      '{0, 32'h00000000, 4'hF, 32'h12345678, 0},
      '{0, 32'h0008F800, 4'hF, 32'h00000000, 3},
      '{0, 32'h0000F800, 4'hF, 32'h00000000, 3},
      '{1, 32'hFFFF0220, 4'h1, 32'h00000001, 0},
      '{0, 32'hFFFF0220, 4'hF, 32'h00000001, 0},
      '{0, 32'h00000000, 4'hF, 32'h1122EE44, 0},
      '{1, 32'h00000004, 4'hF, 32'h0BADF00D, 0},
      '{0, 32'h00040004, 4'hF, 32'h0BADF00D, 0},
      '{0, 32'h00001000, 4'hF, 32'h00000000, 3},
      '{1, 32'hFFFF0220, 4'h1, 32'h00000000, 0},
      '{0, 32'h00000000, 4'hF, 32'h12345678, 0},
      '{1, 32'h20000000, 4'hF, 32'h00000000, 3},
      '{1, 32'hFFFFF010, 4'hF, 32'hDEADBEEF, 0},
      '{0, 32'hFFFFF010, 4'hF, 32'hDEADBEFF, 0}};
    repeat (16) @(posedge clk_sys);
    rst <= 0;
    @(posedge clk_sys);
    // Array word 0 and the first boot word, low half first
    for (int i = 0; i < 4; i++) begin
      progWrite <= 1;
      progAddress <= (i < 2) ? 15'(i) : 15'(32'h7C00 + i - 2);
      progData <= (i == 0) ? 16'h5678 : (i == 1) ? 16'h1234 :
        (i == 2) ? 16'hBBBB : 16'hAAAA;
      @(posedge clk_sys);
    end
    progWrite <= 0;
    chk(32'h2, {29'h0, remapActive, kernelMode, linBootSelect});
    foreach (rows[i]) begin
      acc(rows[i]);
      chk({30'h0, rows[i].rs}, {30'h0, rs});
      chk({31'h0, rows[i].rs == 2'h3}, {31'h0, ab});
      if (!rows[i].w) chk(rows[i].d, rd);
    end
    avs_read <= 0;
    avs_write <= 0;
    stallCycles <= 4'h3;
    @(posedge clk_sys);
    acc('{1, 32'hFFFFF020, 4'hF, 32'h00000F00, 0});
    chk(32'h4, 32'(nCyc));
    chk(32'h00000F00, periphWritedata);
    chk(32'h0000000F, {28'h0, periphByteenable});
    acc('{0, 32'hFFFFF020, 4'hF, 32'h0, 0});
    chk(32'h00000F20, rd);
    chk(32'h4, 32'(nCyc));
    acc('{1, 32'hFFFF0220, 4'h1, 32'h00000001, 0});
    avs_write <= 0;
    dbgTestResetN <= 1;
    extResetN <= 0;
    repeat (2) @(posedge clk_sys);
    extResetN <= 1;
    repeat (2) @(posedge clk_sys);
    chk(32'h3, {29'h0, remapActive, kernelMode, linBootSelect});
    acc('{0, 32'h00000000, 4'hF, 32'h0, 0});
    chk(32'hAAAABBBB, rd);
    acc('{0, 32'hFFFF0224, 4'hF, 32'h0, 0});
    chk(32'h00000003, rd);
    avs_read <= 0;
    finish_test();
  end
endmodule : test_memory_map_decoder_with_remap
